//--- rtl/rofc_sync.sv
// Purpose: Two-stage synchroniser with rising edge strobe
// Assumes: Inputs are slow compared with the core clock
// Notes:   First stage is read only by the second stage

`timescale 1ns/1ns

module rofc_sync #(
  parameter int unsigned W = 1  // Number of lines
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  // Raw lines
  input  wire logic [W-1:0] raw_i,
  // Synchronised level and one-cycle rise
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o
);

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q;  // First stage, metastable
  logic [W-1:0] sync_q;  // Second stage, safe
  logic [W-1:0] prev_q;  // Delayed copy for edge detect

  // Shift the lines through three stages
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge strobe lasts exactly one cycle per input rise
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;

endmodule

//--- rtl/rofc_top.sv
// Purpose: Range and per-axis offset command logic for a 3-axis fluxgate
// Assumes: ref_clk_i is the core clock locked to the host shift pulse
// Notes:   Commands arrive as pulses; codes drive the analog electronics
//
// Function
// - Synchronise every command pulse before use
// - Range, axis, offsets held in static flops
// - One shared two-bit range code
// - Separate three-bit offset code per axis
// - Offset step changes addressed axis only
// - Three-state range, seven-state offset counters
// - Counters hold until advanced
// - Range states: 100, 200, 400 gamma
// - Offsets 0, +-25/50/75 percent, per axis
// - Offset percent follows selected range
// - Normal/reverse input inverts offset polarity
// - Core clock locked to 1060 Hz shift
//
// Added by the designer: the address map and the Wishbone register port.

`timescale 1ns/1ns

module rofc_top
  import rofc_pkg::*;
#(
  parameter int unsigned SHIFT_PERIOD = SHIFT_PERIOD_CYC,  // Cycles per shift pulse
  parameter int unsigned SHIFT_TOL    = SHIFT_TOL_CYC      // Lock tolerance in cycles
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Host command link
  input  wire logic        range_cmd_i,
  input  wire logic        select_cmd_i,
  input  wire logic        offset_cmd_i,
  input  wire logic        shift_pulse_i,
  // Flip programmer, one reverse level per axis X,Y,Z
  input  wire logic [2:0]  flip_reverse_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Sensor electronics codes
  output logic      [1:0]  range_code_o,
  output logic      [2:0]  offset_x_o,
  output logic      [2:0]  offset_y_o,
  output logic      [2:0]  offset_z_o,
  // Timing status
  output logic             shift_lock_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Offset state to sign-magnitude code, bit 2 negative
  function automatic logic [2:0] off_code(input logic [2:0] st, input logic rev);
    logic       neg;
    logic [1:0] mag;
    neg = 1'b0;
    mag = 2'h0;
    if (st != 3'h0 && st <= OFFSET_POS_MAX) begin
      mag = st[1:0];
    end else if (st > OFFSET_POS_MAX) begin
      mag = 2'(st - OFFSET_POS_MAX);
      neg = 1'b1;
    end
    // Flipped sensor sees the field reversed, so flip the sign
    off_code = (mag == 2'h0) ? 3'h0 : {neg ^ rev, mag};
  endfunction

  // Wrapping offset advance
  function automatic logic [2:0] off_next(input logic [2:0] st);
    off_next = (st >= OFFSET_LAST) ? OFFSET_RST : 3'(st + 3'h1);
  endfunction

  // ----------------------------------------------------------------
  // Command synchronisation
  // ----------------------------------------------------------------
  logic [3:0] cmd_rise;    // One-cycle rises: shift, offset, select, range
  logic [2:0] flip_level;  // Synchronised reverse levels

  // Command pulses synchronised before any counter sees them
  rofc_sync #(
    .W (4)
  ) u_cmd_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     ({shift_pulse_i, offset_cmd_i, select_cmd_i, range_cmd_i}),
    .level_o   (),  // Commands act on edges only
    .rise_o    (cmd_rise)
  );

  // Reverse levels are slow, same synchroniser structure
  rofc_sync #(
    .W (3)
  ) u_flip_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .raw_i     (flip_reverse_i),
    .level_o   (flip_level),
    .rise_o    ()   // Reverse acts on the level only
  );

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic        ack_q;       // Registered acknowledge
  logic [31:0] rdata_q;     // Registered read data
  logic        enable_q;    // Link commands accepted
  logic [2:0]  sw_cmd_q;    // Software command strobes
  logic        wr_take;     // Write takes effect this edge
  logic [31:0] state_word;  // Live state view

  // Write lands on the edge where the master samples ack
  assign wr_take  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Ack one cycle after request; drops after one cycle
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // Read data captured with ack; unmapped reads give zero
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= 32'h0;
    end else if (wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i) begin
      case (wb_adr_i)
        ADR_STATE:  rdata_q <= state_word;
        ADR_ENABLE: rdata_q <= {31'h0, enable_q};
        default:    rdata_q <= 32'h0;  // Command register and holes
      endcase
    end
  end

  // Enable register, byte lane 0
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      enable_q <= ENABLE_RST;
    end else if (wr_take && wb_adr_i == ADR_ENABLE && wb_sel_i[0]) begin
      enable_q <= wb_dat_i[0];
    end
  end

  // Software strobes last one cycle, like a link pulse
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sw_cmd_q <= 3'h0;
    end else if (wr_take && wb_adr_i == ADR_CMD && wb_sel_i[0]) begin
      sw_cmd_q <= wb_dat_i[2:0];
    end else begin
      sw_cmd_q <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Advance strobes
  // ----------------------------------------------------------------
  logic range_adv;   // Advance range
  logic select_adv;  // Advance addressed axis
  logic offset_adv;  // Step addressed offset

  // A link pulse and a software write in one cycle give one step
  assign range_adv  = (cmd_rise[0] & enable_q) | sw_cmd_q[CMD_RANGE_BIT];
  assign select_adv = (cmd_rise[1] & enable_q) | sw_cmd_q[CMD_SELECT_BIT];
  assign offset_adv = (cmd_rise[2] & enable_q) | sw_cmd_q[CMD_OFFSET_BIT];

  // ----------------------------------------------------------------
  // Configuration counters
  // ----------------------------------------------------------------
  logic [1:0] range_q;     // Range state, 0..2
  rofc_axis_e axis_q;      // Addressed axis
  logic [2:0] off_q [3];   // Offset state per axis, 0..6

  // Range counter; static, no refresh needed
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      range_q <= RANGE_RST;
    end else if (range_adv) begin
      range_q <= (range_q >= RANGE_LAST) ? RANGE_RST : 2'(range_q + 2'h1);
    end
  end

  // Axis selector steps X, Y, Z and wraps
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      axis_q <= AXIS_X;
    end else if (select_adv) begin
      case (axis_q)
        AXIS_X:  axis_q <= AXIS_Y;
        AXIS_Y:  axis_q <= AXIS_Z;
        AXIS_Z:  axis_q <= AXIS_X;
        default: axis_q <= AXIS_X;  // Recover from unused code
      endcase
    end
  end

  // Only the addressed axis counter steps; others hold
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 3; i++) begin
        off_q[i] <= OFFSET_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (offset_adv && axis_q == rofc_axis_e'(i)) begin
          off_q[i] <= off_next(off_q[i]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output codes
  // ----------------------------------------------------------------
  // Offset codes are fractions of full scale, so a range change
  // rescales the field in the analog ladder with no state change.
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      offset_x_o <= 3'h0;
      offset_y_o <= 3'h0;
      offset_z_o <= 3'h0;
    end else begin
      offset_x_o <= off_code(off_q[0], flip_level[0]);
      offset_y_o <= off_code(off_q[1], flip_level[1]);
      offset_z_o <= off_code(off_q[2], flip_level[2]);
    end
  end

  // One code shared by all axes: 100, 200, 400 gamma
  assign range_code_o = range_q;

  // ----------------------------------------------------------------
  // Shift pulse lock monitor
  // ----------------------------------------------------------------
  // The core clock comes from an oscillator locked to the host shift
  // pulse; this only reports whether that lock looks healthy.
  logic [SHIFT_CNT_W-1:0] shift_cnt_q;  // Cycles since last shift
  logic                   lock_q;       // Period within window

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_cnt_q <= '0;
    end else if (cmd_rise[3]) begin
      shift_cnt_q <= '0;
    end else if (shift_cnt_q != '1) begin
      shift_cnt_q <= SHIFT_CNT_W'(shift_cnt_q + 1'b1);  // Saturates if shift stops
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_q <= 1'b0;
    end else if (cmd_rise[3]) begin
      lock_q <= (shift_cnt_q >= SHIFT_CNT_W'(SHIFT_PERIOD - SHIFT_TOL - 1)) &&
                (shift_cnt_q <= SHIFT_CNT_W'(SHIFT_PERIOD + SHIFT_TOL - 1));
    end else if (shift_cnt_q == '1) begin
      lock_q <= 1'b0;  // Shift pulse lost
    end
  end

  assign shift_lock_o = lock_q;

  // State view for software
  always_comb begin
    state_word = 32'h0;
    state_word[ST_RANGE_LSB +: 2]  = range_q;
    state_word[ST_SELECT_LSB +: 2] = axis_q;
    state_word[ST_OFF_X_LSB +: 3]  = off_q[0];
    state_word[ST_OFF_Y_LSB +: 3]  = off_q[1];
    state_word[ST_OFF_Z_LSB +: 3]  = off_q[2];
    state_word[ST_FLIP_LSB +: 3]   = flip_level;
    state_word[ST_LOCK_BIT]        = lock_q;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sync_delay_a: assert property (enable_q && $rose(range_cmd_i) ##2 enable_q |-> range_adv)
    else $error("range pulse not seen two cycles later");

  range_code_a: assert property (range_code_o != 2'h3)
    else $error("illegal range code");

  range_step_a: assert property (range_adv && range_q < RANGE_LAST |=> range_q == $past(range_q) + 2'h1)
    else $error("range did not step by one");

  range_wrap_a: assert property (range_adv && range_q == RANGE_LAST |=> range_q == RANGE_RST)
    else $error("range did not wrap");

  range_hold_a: assert property (!range_adv |=> $stable(range_q))
    else $error("range changed without command");

  offset_only_a: assert property (offset_adv && axis_q == AXIS_X |=> $stable(off_q[1]) && $stable(off_q[2]))
    else $error("unaddressed axis offset changed");

  offset_wrap_a: assert property (offset_adv && axis_q == AXIS_Y && off_q[1] == OFFSET_LAST |=> off_q[1] == 3'h0)
    else $error("offset did not wrap");

  strobe_single_a: assert property (cmd_rise[0] |=> !cmd_rise[0])
    else $error("link strobe longer than one cycle");

  polarity_a: assert property ($past(off_q[0]) != 3'h0 |->
                               offset_x_o[2] == (($past(off_q[0]) > OFFSET_POS_MAX) ^ $past(flip_level[0])))
    else $error("offset polarity wrong");

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Codes and bus timing that the far side relies on;
  // a negative zero code would drive the ladder with no step at all
  offset_code_a: assert property (offset_x_o != 3'h4 && offset_y_o != 3'h4 && offset_z_o != 3'h4)
    else $error("offset code shows negative zero");

  rescale_keep_a: assert property (range_adv && !offset_adv |=>
                                   $stable(off_q[0]) && $stable(off_q[1]) && $stable(off_q[2]))
    else $error("range change moved an offset state");

  select_wrap_a: assert property (select_adv && axis_q == AXIS_Z |=> axis_q == AXIS_X)
    else $error("axis select did not wrap to X");

  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  // Main scenarios worth seeing at least once
  range_wrap_c:  cover property (range_adv && range_q == RANGE_LAST);
  offset_neg_c:  cover property (offset_x_o[2] && flip_level[0]);
  sw_command_c:  cover property (sw_cmd_q[CMD_OFFSET_BIT] && axis_q == AXIS_Z);
  shift_lock_c:  cover property ($rose(lock_q));
  reverse_x_c:   cover property (flip_level[0] && off_q[0] > OFFSET_POS_MAX);

endmodule

//--- shared/rofc_pkg.sv
// Purpose: Shared constants for the range/offset command logic
// Assumes: 50 MHz core clock locked to the host shift pulse
// Notes:   Offsets are Wishbone byte addresses, one 32-bit word each

package rofc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ      = 50_000_000;  // Core clock rate
  localparam int unsigned SHIFT_FREQ_HZ    = 1060;        // Host shift pulse rate
  localparam int unsigned SHIFT_PERIOD_CYC = CLK_FREQ_HZ / SHIFT_FREQ_HZ; // Rounded down
  localparam int unsigned SHIFT_TOL_CYC    = SHIFT_PERIOD_CYC / 64;       // Lock window half width
  localparam int unsigned SHIFT_CNT_W      = 20;          // Period counter width

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CMD    = 8'h00;  // Write-one command strobes
  localparam logic [7:0] ADR_STATE  = 8'h04;  // Read-only configuration state
  localparam logic [7:0] ADR_ENABLE = 8'h08;  // Link command enable

  // Command register bit positions
  localparam int unsigned CMD_RANGE_BIT  = 0;  // Advance range
  localparam int unsigned CMD_SELECT_BIT = 1;  // Advance addressed axis
  localparam int unsigned CMD_OFFSET_BIT = 2;  // Step addressed axis offset

  // State register field positions
  localparam int unsigned ST_RANGE_LSB  = 0;   // [1:0] range state
  localparam int unsigned ST_SELECT_LSB = 2;   // [3:2] addressed axis
  localparam int unsigned ST_OFF_X_LSB  = 4;   // [6:4] X offset state
  localparam int unsigned ST_OFF_Y_LSB  = 7;   // [9:7] Y offset state
  localparam int unsigned ST_OFF_Z_LSB  = 10;  // [12:10] Z offset state
  localparam int unsigned ST_FLIP_LSB   = 13;  // [15:13] reverse levels X,Y,Z
  localparam int unsigned ST_LOCK_BIT   = 16;  // Shift pulse lock

  // ----------------------------------------------------------------
  // Counter ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RANGE_LAST    = 2'h2;  // Three range states 0..2
  localparam logic [2:0] OFFSET_LAST   = 3'h6;  // Seven offset states 0..6
  localparam logic [2:0] OFFSET_POS_MAX = 3'h3; // States 1..3 positive
  localparam logic [1:0] RANGE_RST     = 2'h0;  // Lowest range
  localparam logic [2:0] OFFSET_RST    = 3'h0;  // Zero offset
  localparam logic       ENABLE_RST    = 1'b1;  // Link commands accepted

  // Range codes: 100, 200, 400 gamma full scale
  localparam logic [1:0] RANGE_100 = 2'h0;
  localparam logic [1:0] RANGE_200 = 2'h1;
  localparam logic [1:0] RANGE_400 = 2'h2;

  // Addressed axis
  typedef enum logic [1:0] {
    AXIS_X,
    AXIS_Y,
    AXIS_Z
  } rofc_axis_e;

endpackage

//--- tb/rofc_host_model.sv
// Purpose: Host command link, shift pulse source and flip programmer
// Assumes: Commands are level pulses of chosen width
// Notes:   Period 0 stops the shift pulse so the lock stays clear
`timescale 1ns/1ns
module rofc_host_model (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Shift period in cycles
  input  wire logic [15:0] period_i,
  // Link side
  output logic      [2:0]  cmd_o,
  output logic             shift_pulse_o,
  output logic      [2:0]  flip_o
);
  logic [15:0] cnt_q;  // Shift period counter

  initial begin
    cmd_o  = 3'h0;
    flip_o = 3'h0;
  end

  // ------------------------------------------------
  // Shift pulse, one cycle high per period
  // ------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q         <= 16'h0000;
      shift_pulse_o <= 1'b0;
    end else begin
      cnt_q         <= (cnt_q + 16'h0001 >= period_i) ? 16'h0000 : cnt_q + 16'h0001;
      shift_pulse_o <= (period_i != 16'h0000) && (cnt_q == 16'h0000);
    end
  end

  // Pulse of width cycles, then two low cycles before the next one
  task automatic send(input int unsigned k, input int unsigned width);
    @(posedge ref_clk_i);
    cmd_o[k] <= 1'b1;
    repeat (width) @(posedge ref_clk_i);
    cmd_o[k] <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  // Reverse levels follow the sensor orientation
  task automatic set_flip(input logic [2:0] v);
    @(posedge ref_clk_i);
    flip_o <= v;
  endtask
endmodule

//--- tb/test_range_offset_command_logic.sv
// Purpose: Self-checking bench for the range/offset command logic
// Assumes: Shortened shift period; link and software both advance
// Notes:   Expected codes come from a small model in this bench
`timescale 1ns/1ns
module test_range_offset_command_logic;
  import rofc_pkg::*;
  localparam int unsigned PER = 100;  // Short shift period
  localparam int unsigned TOL = 4;    // Short lock window
  logic        ref_clk_i;
  logic        reset_i;
  logic [2:0]  cmd;
  logic        shift;
  logic [2:0]  flip;
  logic [15:0] period;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [1:0]  range_code_o;
  logic [2:0]  offset_x_o;
  logic [2:0]  offset_y_o;
  logic [2:0]  offset_z_o;
  logic        shift_lock_o;
  // Expected state
  logic [1:0]  rng;
  logic [1:0]  axis;
  logic [2:0]  off [3];
  logic [2:0]  rev;
  logic        lock;
  logic [31:0] rd;
  int          n_errors;
  int          cmp_count;

  rofc_top #(.SHIFT_PERIOD(PER), .SHIFT_TOL(TOL)) i_rofc_top (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .range_cmd_i(cmd[0]), .select_cmd_i(cmd[1]),
    .offset_cmd_i(cmd[2]), .shift_pulse_i(shift), .flip_reverse_i(flip), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .range_code_o(range_code_o),
    .offset_x_o(offset_x_o), .offset_y_o(offset_y_o), .offset_z_o(offset_z_o),
    .shift_lock_o(shift_lock_o));

  rofc_host_model i_rofc_host_model (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .period_i(period), .cmd_o(cmd),
    .shift_pulse_o(shift), .flip_o(flip));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic complete_run();
    $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single cycle; bounded wait for ack
  task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] wd,
                         output logic [31:0] rdat);
    int unsigned n;
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    if (n >= 50) begin
      n_errors++;
      complete_run();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Sign-magnitude code a state should produce
  function automatic logic [2:0] code(input logic [2:0] s, input logic r);
    logic [2:0] m;
    m = (s > 3'h3) ? s - 3'h3 : s;
    if (s == 3'h0) return 3'h0;
    return {(s > 3'h3) ^ r, m[1:0]};
  endfunction

  // Advance the expected state; wraps at the last state
  task automatic step(input int unsigned k);
    case (k)
      0: rng = (rng == 2'h2) ? 2'h0 : rng + 2'h1;
      1: axis = (axis == 2'h2) ? 2'h0 : axis + 2'h1;
      default: off[axis] = (off[axis] == 3'h6) ? 3'h0 : off[axis] + 3'h1;
    endcase
    repeat (5) @(posedge ref_clk_i);
  endtask

  task automatic link(input int unsigned k, input int unsigned w);
    i_rofc_host_model.send(k, w);
    step(k);
  endtask

  task automatic sw(input int unsigned k);
    wb_xfer(ADR_CMD, 1'b1, 32'h1 << k, rd);
    step(k);
  endtask

  task automatic check_all();
    check("range_code", {30'h0, rng}, {30'h0, range_code_o});
    check("offset_x", {29'h0, code(off[0], rev[0])}, {29'h0, offset_x_o});
    check("offset_y", {29'h0, code(off[1], rev[1])}, {29'h0, offset_y_o});
    check("offset_z", {29'h0, code(off[2], rev[2])}, {29'h0, offset_z_o});
    wb_xfer(ADR_STATE, 1'b0, 32'h0, rd);
    check("state", {15'h0, lock, rev, off[2], off[1], off[0], axis, rng}, rd);
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    n_errors = 0;
    cmp_count = 0;
    reset_i = 1'b1;
    period = 16'h0000;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    rng = 2'h0;
    axis = 2'h0;
    off = '{3'h0, 3'h0, 3'h0};
    rev = 3'h0;
    lock = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    check_all();
    wb_xfer(ADR_ENABLE, 1'b0, 32'h0, rd);
    check("enable", 32'h1, rd);
    // Range wrap by link, prompt and slow pulses
    for (int i = 0; i < 4; i++) begin
      link(0, 2 + 3 * i);
      check_all();
    end
    // X offset through all seven states and wrap
    for (int i = 0; i < 7; i++) begin
      sw(2);
      check_all();
    end
    // Address Y then Z; only the addressed axis moves
    link(1, 2);
    link(2, 2);
    link(2, 2);
    check_all();
    sw(1);
    sw(2);
    check_all();
    // Range change keeps offset states
    sw(0);
    check_all();
    // Reverse levels invert nonzero offsets only
    i_rofc_host_model.set_flip(3'h7);
    rev = 3'h7;
    repeat (5) @(posedge ref_clk_i);
    check_all();
    // Reversed X axis through positive states and the first negative one
    link(1, 2);
    for (int i = 0; i < 4; i++) begin
      sw(2);
      check_all();
    end
    // Link disabled: pulse ignored, state held
    wb_xfer(ADR_ENABLE, 1'b1, 32'h0, rd);
    i_rofc_host_model.send(0, 2);
    repeat (5) @(posedge ref_clk_i);
    check_all();
    wb_xfer(ADR_ENABLE, 1'b1, 32'h1, rd);
    // Unmapped place and write-only strobes read zero
    wb_xfer(8'h0C, 1'b1, 32'hFFFF_FFFF, rd);
    wb_xfer(8'h0C, 1'b0, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    wb_xfer(ADR_CMD, 1'b0, 32'h0, rd);
    check("cmd_read", 32'h0, rd);
    // Shift lock gained on the nominal period, lost on a short one
    period <= 16'(PER);
    repeat (3 * PER + 10) @(posedge ref_clk_i);
    lock = 1'b1;
    check("lock_on", 32'h1, {31'h0, shift_lock_o});
    check_all();
    period <= 16'(PER / 2);
    repeat (2 * PER) @(posedge ref_clk_i);
    lock = 1'b0;
    check("lock_off", 32'h0, {31'h0, shift_lock_o});
    complete_run();
  end
endmodule
